// ---- sbrca_consts.vh ----
// shared constants for the bank, row and column access block
`ifndef SBRCA_CONSTS_VH
`define SBRCA_CONSTS_VH
`define SBRCA_CMD_ADDR_W 10
`define SBRCA_BA_LSB 7
`define SBRCA_ROW_HI_LSB 2
`define SBRCA_ROW_HI_W 4
`define SBRCA_COL_TOP_BIT 6
`define SBRCA_COL_NEXT_BIT 5
`define SBRCA_COL_MID_LSB 3
`define SBRCA_COL_MID_W 7
`define SBRCA_BANKS 8
`define SBRCA_BA_W 3
`define SBRCA_ROW_W 14
`define SBRCA_COL_W 10
`define SBRCA_BEATS 8
`define SBRCA_BEAT_IDX_W 3
`define SBRCA_DQ_W 32
`define SBRCA_BYTES 4
`define SBRCA_CORE_W 256
`define SBRCA_MASK_W 32
`define SBRCA_FIFO_DEPTH 8
`define SBRCA_FIFO_AW 3
`define SBRCA_CMD_NONE 3'h0
`define SBRCA_CMD_ACT 3'h1
`define SBRCA_CMD_RD 3'h2
`define SBRCA_CMD_WR 3'h3
`define SBRCA_CMD_PRE 3'h4
`define SBRCA_ACT_CODE 2'h2
`define SBRCA_RD_CODE 3'h5
`define SBRCA_WR_CODE 3'h1
`define SBRCA_PRE_CODE 4'hb
`define SBRCA_X16_DQ_EN 32'h0000ffff
`define SBRCA_X16_BYTE_MASK 4'hc
`define SBRCA_X16_DQS_EN 4'h3
`define SBRCA_PHASE_RISE 1'b0
`endif

// ---- sbrca_fifo.v ----
// parameterised fifo for read data words
`timescale 1ns/1ps
module sbrca_fifo #(
  parameter WIDTH = 259,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire mclk,
  input wire rstn,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0] wr_ptr_q;
  reg [AW:0] rd_ptr_q;
  wire full;
  wire empty;
  wire push;
  wire pop;
  assign empty = (wr_ptr_q == rd_ptr_q);
  assign full = (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]) && (wr_ptr_q[AW] != rd_ptr_q[AW]);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign push = in_valid & ~full;
  assign pop = out_ready & ~empty;
  assign out_data = mem_q[rd_ptr_q[AW-1:0]];
  always @(posedge mclk) begin
    if (push) begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end
  always @(posedge mclk) begin
    if (!rstn) begin
      wr_ptr_q <= {(AW+1){1'b0}};
      rd_ptr_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end
endmodule // sbrca_fifo

// ---- sbrca_top.v ----
// device side command decode, bank rows and burst data path
`timescale 1ns/1ps
`include "sbrca_consts.vh"
module sbrca_top (
  // clock and reset
  input wire mclk,
  input wire rstn,
  // configuration strap, high for x32
  input wire cfg_x32,
  // command pins
  input wire cs_n,
  input wire cke,
  input wire [`SBRCA_CMD_ADDR_W-1:0] command_address_bus,
  // data pins
  input wire [`SBRCA_DQ_W-1:0] dq_i,
  output reg [`SBRCA_DQ_W-1:0] dq_o,
  output reg [`SBRCA_DQ_W-1:0] dq_oe,
  output reg [`SBRCA_BYTES-1:0] dqs_t_o,
  output reg [`SBRCA_BYTES-1:0] dqs_c_o,
  output reg [`SBRCA_BYTES-1:0] dqs_oe,
  input wire [`SBRCA_BYTES-1:0] write_byte_mask,
  // core side
  output reg core_cmd_valid,
  output reg core_we,
  output reg [`SBRCA_BA_W-1:0] core_bank,
  output reg [`SBRCA_ROW_W-1:0] core_row,
  output reg [`SBRCA_COL_W-1:0] core_col,
  output reg [`SBRCA_CORE_W-1:0] core_wdata,
  output reg [`SBRCA_MASK_W-1:0] core_wmask,
  input wire core_rd_valid,
  output wire core_rd_ready,
  input wire [`SBRCA_CORE_W-1:0] core_rd_data,
  // status
  output wire [`SBRCA_BANKS-1:0] bank_open
);
  function [2:0] cmd_decode;
    input [`SBRCA_CMD_ADDR_W-1:0] r;
    begin
      if (r[1:0] == `SBRCA_ACT_CODE) begin
        cmd_decode = `SBRCA_CMD_ACT;
      end else if (r[2:0] == `SBRCA_RD_CODE) begin
        cmd_decode = `SBRCA_CMD_RD;
      end else if (r[2:0] == `SBRCA_WR_CODE) begin
        cmd_decode = `SBRCA_CMD_WR;
      end else if (r[3:0] == `SBRCA_PRE_CODE) begin
        cmd_decode = `SBRCA_CMD_PRE;
      end else begin
        cmd_decode = `SBRCA_CMD_NONE;
      end
    end
  endfunction
  // beat lane in sequential wrap order
  function [`SBRCA_BEAT_IDX_W-1:0] beat_lane;
    input [`SBRCA_BEAT_IDX_W-1:0] start;
    input [`SBRCA_BEAT_IDX_W-1:0] cnt;
    begin
      beat_lane = start + cnt;
    end
  endfunction
  // input synchronisers
  reg [`SBRCA_CMD_ADDR_W-1:0] cmd_addr_m, cmd_addr_s;
  reg cs_n_m, cs_n_s, cke_m, cke_s, x32_m, x32_s;
  reg [`SBRCA_DQ_W-1:0] dq_m, dq_s;
  reg [`SBRCA_BYTES-1:0] wmask_m, wmask_s;
  always @(posedge mclk) begin
    cmd_addr_m <= command_address_bus;
    cmd_addr_s <= cmd_addr_m;
    cs_n_m <= cs_n;
    cs_n_s <= cs_n_m;
    cke_m <= cke;
    cke_s <= cke_m;
    x32_m <= cfg_x32;
    x32_s <= x32_m;
    dq_m <= dq_i;
    dq_s <= dq_m;
    wmask_m <= write_byte_mask;
    wmask_s <= wmask_m;
  end
  reg phase_q, init_done_q, x32_q, cmd_pend_q;
  reg [`SBRCA_CMD_ADDR_W-1:0] rise_q;
  wire [2:0] cmd;
  wire [`SBRCA_BA_W-1:0] cmd_bank;
  wire [`SBRCA_ROW_W-1:0] cmd_row;
  wire [`SBRCA_COL_W-1:0] cmd_col;
  wire decode_en;
  assign decode_en = cmd_pend_q && (phase_q != `SBRCA_PHASE_RISE);
  assign cmd = decode_en ? cmd_decode(rise_q) : `SBRCA_CMD_NONE;
  assign cmd_bank = rise_q[`SBRCA_BA_LSB +: `SBRCA_BA_W];
  assign cmd_row = {rise_q[`SBRCA_ROW_HI_LSB +: `SBRCA_ROW_HI_W], cmd_addr_s};
  assign cmd_col = {(x32_q ? 1'b0 : rise_q[`SBRCA_COL_TOP_BIT]), rise_q[`SBRCA_COL_NEXT_BIT],
    cmd_addr_s[`SBRCA_COL_MID_LSB +: `SBRCA_COL_MID_W], 1'b0};
  // half-clock phase and command capture
  always @(posedge mclk) begin
    if (!rstn) begin
      phase_q <= `SBRCA_PHASE_RISE;
      init_done_q <= 1'b0;
      x32_q <= 1'b0;
      cmd_pend_q <= 1'b0;
      rise_q <= {`SBRCA_CMD_ADDR_W{1'b0}};
    end else begin
      phase_q <= ~phase_q;
      if (!init_done_q) begin
        x32_q <= x32_s;
        init_done_q <= 1'b1;
      end
      if (phase_q == `SBRCA_PHASE_RISE) begin
        cmd_pend_q <= init_done_q & ~cs_n_s & cke_s;
        rise_q <= cmd_addr_s;
      end else begin
        cmd_pend_q <= 1'b0;
      end
    end
  end
  // per bank open row state
  reg [`SBRCA_ROW_W-1:0] row_sel;
  wire [`SBRCA_ROW_W*`SBRCA_BANKS-1:0] rows_flat;
  genvar gb;
  generate
    for (gb = 0; gb < `SBRCA_BANKS; gb = gb + 1) begin : g_bank
      reg open_q;
      reg [`SBRCA_ROW_W-1:0] row_q;
      always @(posedge mclk) begin
        if (!rstn) begin
          open_q <= 1'b0;
          row_q <= {`SBRCA_ROW_W{1'b0}};
        end else if (cmd_bank == gb) begin
          if (cmd == `SBRCA_CMD_ACT) begin
            open_q <= 1'b1;
            row_q <= cmd_row;
          end else if (cmd == `SBRCA_CMD_PRE) begin
            open_q <= 1'b0;
          end
        end
      end
      assign bank_open[gb] = open_q;
      assign rows_flat[gb*`SBRCA_ROW_W +: `SBRCA_ROW_W] = row_q;
    end
  endgenerate
  always @* begin
    row_sel = rows_flat[cmd_bank*`SBRCA_ROW_W +: `SBRCA_ROW_W];
  end
  wire bank_ok;
  assign bank_ok = bank_open[cmd_bank];
  // write deserialiser and core request
  reg wr_busy_q;
  reg [`SBRCA_BEAT_IDX_W-1:0] wcnt_q, wstart_q;
  reg [`SBRCA_BA_W-1:0] wbank_q;
  reg [`SBRCA_ROW_W-1:0] wrow_q;
  reg [`SBRCA_COL_W-1:0] wcol_q;
  wire [`SBRCA_BEAT_IDX_W-1:0] wlane;
  wire [`SBRCA_BYTES-1:0] wbyte_mask;
  assign wlane = beat_lane(wstart_q, wcnt_q);
  assign wbyte_mask = wmask_s | (x32_q ? {`SBRCA_BYTES{1'b0}} : `SBRCA_X16_BYTE_MASK);
  always @(posedge mclk) begin
    if (!rstn) begin
      wr_busy_q <= 1'b0;
      wcnt_q <= {`SBRCA_BEAT_IDX_W{1'b0}};
      wstart_q <= {`SBRCA_BEAT_IDX_W{1'b0}};
      wbank_q <= {`SBRCA_BA_W{1'b0}};
      wrow_q <= {`SBRCA_ROW_W{1'b0}};
      wcol_q <= {`SBRCA_COL_W{1'b0}};
      core_cmd_valid <= 1'b0;
      core_we <= 1'b0;
      core_bank <= {`SBRCA_BA_W{1'b0}};
      core_row <= {`SBRCA_ROW_W{1'b0}};
      core_col <= {`SBRCA_COL_W{1'b0}};
      core_wdata <= {`SBRCA_CORE_W{1'b0}};
      core_wmask <= {`SBRCA_MASK_W{1'b0}};
    end else begin
      core_cmd_valid <= 1'b0;
      if (wr_busy_q) begin
        core_wdata[{wlane, 5'h00} +: `SBRCA_DQ_W] <= dq_s;
        core_wmask[{wlane, 2'h0} +: `SBRCA_BYTES] <= wbyte_mask;
        wcnt_q <= wcnt_q + 1'b1;
        if (wcnt_q == `SBRCA_BEATS - 1) begin
          wr_busy_q <= 1'b0;
          core_cmd_valid <= 1'b1;
          core_we <= 1'b1;
          core_bank <= wbank_q;
          core_row <= wrow_q;
          core_col <= wcol_q;
        end
      end else if (cmd == `SBRCA_CMD_WR && bank_ok) begin
        wr_busy_q <= 1'b1;
        wcnt_q <= {`SBRCA_BEAT_IDX_W{1'b0}};
        wstart_q <= cmd_col[2:0];
        wbank_q <= cmd_bank;
        wrow_q <= row_sel;
        wcol_q <= cmd_col;
      end
      if (!wr_busy_q && cmd == `SBRCA_CMD_RD && bank_ok) begin
        core_cmd_valid <= 1'b1;
        core_we <= 1'b0;
        core_bank <= cmd_bank;
        core_row <= row_sel;
        core_col <= cmd_col;
      end
    end
  end
  // read start offset register follows read requests
  reg [`SBRCA_BEAT_IDX_W-1:0] rd_start_q;
  always @(posedge mclk) begin
    if (!rstn) begin
      rd_start_q <= {`SBRCA_BEAT_IDX_W{1'b0}};
    end else if (!wr_busy_q && cmd == `SBRCA_CMD_RD && bank_ok) begin
      rd_start_q <= cmd_col[2:0];
    end
  end
  // read data buffer
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [`SBRCA_CORE_W+`SBRCA_BEAT_IDX_W-1:0] fifo_out_data;
  reg rd_busy_q;
  reg [`SBRCA_BEAT_IDX_W-1:0] rcnt_q, rstart_q;
  reg [`SBRCA_CORE_W-1:0] rword_q;
  assign fifo_out_ready = ~rd_busy_q;
  sbrca_fifo #(
    .WIDTH(`SBRCA_CORE_W + `SBRCA_BEAT_IDX_W),
    .DEPTH(`SBRCA_FIFO_DEPTH),
    .AW(`SBRCA_FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .rstn(rstn),
    .in_valid(core_rd_valid),
    .in_ready(core_rd_ready),
    .in_data({rd_start_q, core_rd_data}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );
  // read serialiser, one beat per half clock
  wire [`SBRCA_BEAT_IDX_W-1:0] rlane;
  assign rlane = beat_lane(rstart_q, rcnt_q);
  always @(posedge mclk) begin
    if (!rstn) begin
      rd_busy_q <= 1'b0;
      rcnt_q <= {`SBRCA_BEAT_IDX_W{1'b0}};
      rstart_q <= {`SBRCA_BEAT_IDX_W{1'b0}};
      rword_q <= {`SBRCA_CORE_W{1'b0}};
      dq_o <= {`SBRCA_DQ_W{1'b0}};
      dq_oe <= {`SBRCA_DQ_W{1'b0}};
      dqs_t_o <= {`SBRCA_BYTES{1'b0}};
      dqs_c_o <= {`SBRCA_BYTES{1'b1}};
      dqs_oe <= {`SBRCA_BYTES{1'b0}};
    end else if (rd_busy_q) begin
      dq_o <= rword_q[{rlane, 5'h00} +: `SBRCA_DQ_W];
      dq_oe <= x32_q ? {`SBRCA_DQ_W{1'b1}} : `SBRCA_X16_DQ_EN;
      dqs_t_o <= {`SBRCA_BYTES{~rcnt_q[0]}};
      dqs_c_o <= {`SBRCA_BYTES{rcnt_q[0]}};
      dqs_oe <= x32_q ? {`SBRCA_BYTES{1'b1}} : `SBRCA_X16_DQS_EN;
      rcnt_q <= rcnt_q + 1'b1;
      if (rcnt_q == `SBRCA_BEATS - 1) begin
        rd_busy_q <= 1'b0;
      end
    end else begin
      dq_oe <= {`SBRCA_DQ_W{1'b0}};
      dqs_oe <= {`SBRCA_BYTES{1'b0}};
      dqs_t_o <= {`SBRCA_BYTES{1'b0}};
      dqs_c_o <= {`SBRCA_BYTES{1'b1}};
      if (fifo_out_valid) begin
        rd_busy_q <= 1'b1;
        rcnt_q <= {`SBRCA_BEAT_IDX_W{1'b0}};
        rword_q <= fifo_out_data[`SBRCA_CORE_W-1:0];
        rstart_q <= fifo_out_data[`SBRCA_CORE_W +: `SBRCA_BEAT_IDX_W];
      end
    end
  end
endmodule // sbrca_top

// ---- sbrca_chk_asserts.sv ----
// port checks for the access block
`timescale 1ns/1ps
module sbrca_chk (
  // clock and reset
  input logic mclk,
  input logic rstn,
  // strap and select
  input logic cfg_x32,
  input logic cs_n,
  // data pins
  input logic [31:0] dq_oe,
  input logic [3:0] dqs_t_o,
  input logic [3:0] dqs_oe,
  // core side
  input logic core_cmd_valid,
  input logic core_we,
  input logic [2:0] core_bank,
  input logic [9:0] core_col,
  input logic [31:0] core_wmask,
  input logic [7:0] bank_open
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  col_lsb_zero_a: assert property (core_cmd_valid |-> !core_col[0])
    else $error("column lsb set");
  x32_col_top_a: assert property (core_cmd_valid && cfg_x32 |-> !core_col[9])
    else $error("x32 column top bit set");
  open_bank_a: assert property (core_cmd_valid |-> bank_open[core_bank])
    else $error("access to closed bank");
  x16_lanes_a: assert property (!cfg_x32 |-> dq_oe[31:16] == 16'h0 && dqs_oe[3:2] == 2'h0)
    else $error("x16 upper lanes driven");
  x16_mask_a: assert property (core_cmd_valid && core_we && !cfg_x32 |-> &(core_wmask | 32'h33333333))
    else $error("x16 upper bytes not masked");
  burst_len_a: assert property ($rose(dqs_oe[0]) |-> (dqs_t_o[0] && dq_oe[0]) ##0 dqs_oe[0] [*8] ##1 !dqs_oe[0])
    else $error("read burst length");
  strobe_alt_a: assert property (dqs_oe[0] && $past(dqs_oe[0]) |-> dqs_t_o[0] != $past(dqs_t_o[0]))
    else $error("strobe not toggling");
  act_cause_a: assert property ((bank_open & ~$past(bank_open)) != 8'h0 |-> !$past(cs_n, 3) || !$past(cs_n, 4) || !$past(cs_n, 5))
    else $error("bank opened without select");
  cover property (core_cmd_valid && core_we);
  cover property (core_cmd_valid && !core_we);
  cover property ($rose(dqs_oe[0]));
endmodule // sbrca_chk
bind sbrca_top sbrca_chk u_chk (.*);

// ---- sbrca_ctl_model.sv ----
// controller side pin driver
`timescale 1ns/1ps
module sbrca_ctl_model (
  // clock and reset
  input logic mclk,
  input logic rstn,
  // command pins
  output logic cs_n,
  output logic cke,
  output logic [9:0] command_address_bus,
  // write data pins
  output logic [31:0] dq_i,
  output logic [3:0] write_byte_mask
);
  logic ph_q = 1'b0;
  // phase, rise words leave on even edges
  always @(posedge mclk) ph_q <= rstn ? ~ph_q : 1'b0;
  initial begin
    cs_n = 1'b1;
    cke = 1'b1;
    command_address_bus = 10'h0;
    dq_i = 32'h0;
    write_byte_mask = 4'h0;
  end
  task automatic send(input logic [9:0] r, input logic [9:0] f, input logic en,
    input int nb, input logic [255:0] d, input logic [31:0] m);
    do @(negedge mclk); while (ph_q !== 1'b1);
    @(posedge mclk);
    cs_n <= 1'b0;
    cke <= en;
    command_address_bus <= r;
    @(posedge mclk);
    cs_n <= 1'b1;
    command_address_bus <= f;
    for (int i = 0; i < nb; i++) begin
      @(posedge mclk);
      dq_i <= d[32*i+:32];
      write_byte_mask <= m[4*i+:4];
    end
    @(posedge mclk);
    cke <= 1'b1;
    command_address_bus <= ~f;
    dq_i <= ~dq_i;
    write_byte_mask <= ~write_byte_mask;
  endtask
endmodule // sbrca_ctl_model

// ---- tb_top.sv ----
// self-checking bench for the access block
`timescale 1ns/1ps
module tb_top;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic cfg_x32 = 1'b1;
  logic core_rd_valid = 1'b0;
  logic [255:0] core_rd_data = 256'h0;
  logic cs_n, cke, core_cmd_valid, core_we, core_rd_ready;
  logic [9:0] command_address_bus, core_col;
  logic [31:0] dq_i, dq_o, dq_oe, core_wmask;
  logic [3:0] write_byte_mask, dqs_t_o, dqs_c_o, dqs_oe;
  logic [2:0] core_bank, last_st;
  logic [13:0] core_row;
  logic [255:0] core_wdata;
  logic [7:0] bank_open;
  logic [13:0] rows [8];
  logic [31:0] s = 32'h0d587a26;
  logic [31:0] q [$];
  int errors = 0;
  int n_checks = 0;
  int stalls = 0;
  always #5 mclk = ~mclk;
  sbrca_top dut (.*);
  sbrca_ctl_model u_ctl (.*);
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // read beats against the expected queue
  always @(negedge mclk) if (rstn && dqs_oe[0] === 1'b1) begin
    chk("dq_oe", cfg_x32 ? 32'hffffffff : 32'h0000ffff, dq_oe);
    chk("dqs_oe", cfg_x32 ? 32'hf : 32'h3, dqs_oe);
    chk("dqs_t", (q.size() % 2 == 0) ? dqs_oe : 4'h0, dqs_t_o & dqs_oe);
    chk("dqs_c", (q.size() % 2 == 0) ? 4'h0 : dqs_oe, dqs_c_o & dqs_oe);
    chk("dq_o", q.pop_front() & dq_oe, dq_o & dq_oe);
  end
  always @(negedge mclk) if (core_rd_valid && core_rd_ready === 1'b0) stalls++;
  task automatic push(input logic [255:0] w, input logic [2:0] st);
    @(posedge mclk);
    core_rd_valid <= 1'b1;
    core_rd_data <= w;
    @(negedge mclk);
    while (core_rd_ready !== 1'b1) @(negedge mclk);
    for (int i = 0; i < 8; i++) q.push_back(w[32*((st + i) % 8)+:32]);
    @(posedge mclk);
    core_rd_valid <= 1'b0;
  endtask
  task automatic act(input logic [2:0] b, input logic en, input logic pre);
    logic [31:0] r;
    r = rnd();
    if (en && !pre) rows[b] = r[13:0];
    u_ctl.send(pre ? {b, r[2:0], 4'hb} : {b, r[14], r[13:10], 2'h2}, r[9:0], en, 0, 0, 0);
    repeat (4) @(negedge mclk);
    chk("bank_open", en & ~pre, bank_open[b]);
  endtask
  task automatic access(input logic we, input logic [2:0] b, input logic [9:0] c, input logic hit);
    logic [255:0] d;
    logic [31:0] m, r, bm;
    logic [9:0] ec;
    logic [3:0] em;
    logic seen;
    int l;
    r = rnd();
    m = rnd() & rnd();
    for (int i = 0; i < 8; i++) d[32*i+:32] = rnd();
    ec = {cfg_x32 ? 1'b0 : c[9], c[8:1], 1'b0};
    u_ctl.send({b, c[9:8], r[1:0], we ? 3'h1 : 3'h5}, {c[7:1], r[4:2]}, 1'b1, we ? 8 : 0, d, m);
    seen = 1'b0;
    for (int i = 0; i < 16 && !seen; i++) begin
      @(negedge mclk);
      seen = core_cmd_valid === 1'b1;
    end
    chk("cmd_seen", hit, seen);
    if (seen) begin
      chk("we", we, core_we);
      chk("bank", b, core_bank);
      chk("row", rows[b], core_row);
      chk("col", ec, core_col);
      if (we) begin
        for (int i = 0; i < 8; i++) begin
          l = (ec[2:0] + i) % 8;
          em = m[4*i+:4] | (cfg_x32 ? 4'h0 : 4'hc);
          bm = {{8{~em[3]}}, {8{~em[2]}}, {8{~em[1]}}, {8{~em[0]}}};
          chk("wmask", em, core_wmask[4*l+:4]);
          chk("wdata", d[32*i+:32] & bm, core_wdata[32*l+:32] & bm);
        end
      end else begin
        last_st = ec[2:0];
        push(d, ec[2:0]);
      end
    end
  endtask
  initial begin
    #300000;
    errors++;
    print_verdict();
  end
  initial begin
    logic [31:0] r;
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      rstn <= 1'b0;
      cfg_x32 <= (k == 0);
      stalls = 0;
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      repeat (4) @(posedge mclk);
      chk("bank_open", 32'h0, bank_open);
      access(1'b0, 3'h2, 10'h010, 1'b0);
      act(3'h2, 1'b0, 1'b0);
      act(3'h2, 1'b1, 1'b0);
      act(3'h6, 1'b1, 1'b0);
      access(1'b1, 3'h6, 10'h3ff, 1'b1);
      access(1'b0, 3'h6, 10'h3ff, 1'b1);
      repeat (8) begin
        r = rnd();
        access(r[0], r[1] ? 3'h2 : 3'h6, r[11:2], 1'b1);
      end
      act(3'h6, 1'b1, 1'b1);
      access(1'b1, 3'h6, 10'h040, 1'b0);
      access(1'b0, 3'h2, 10'h2a6, 1'b1);
      repeat (11) push({rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()}, last_st);
      for (int i = 0; i < 300 && q.size() > 0; i++) @(negedge mclk);
      chk("left", 0, q.size());
      chk("full", 1, stalls > 0);
    end
    print_verdict();
  end
endmodule // tb_top
